// ==== core/pagp_cfg.svh ====
`ifndef PAGP_CFG_SVH
`define PAGP_CFG_SVH

// register offsets on the plain register port
`define PAGP_ADDR_W        4
`define PAGP_OFF_DIR       4'h0
`define PAGP_OFF_DATA      4'h1
`define PAGP_OFF_CTRL      4'h2
`define PAGP_OFF_STATUS    4'h3

// reset values and the all-ones direction read value
`define PAGP_DIR_RST_LOW   8'h00
`define PAGP_DIR_RST_ADDR  8'h80
`define PAGP_DATA_RST      8'h00
`define PAGP_CTRL_RST      8'h00
`define PAGP_DIR_READ      8'hff

// field positions
`define PAGP_PIN7          7
`define PAGP_CTRL_PAT7     0
`define PAGP_CTRL_TIMER2_B_CTRL_BIT0     1
`define PAGP_CTRL_TIMER2_B_CTRL_BIT1     2
`define PAGP_CTRL_TIMER2_B_CTRL_BIT2     3
`define PAGP_CTRL_TIMER2_PWM_SELECT     4

`endif

// ==== core/pagp_pin_cell.sv ====
`timescale 1ns/1ps
`default_nettype none
// one port pin: direction, output drive and read-back mux
module pagp_pin_cell (
  input  wire logic dir_i,
  input  wire logic out_val_i,
  input  wire logic pin_level_i,
  output logic      drive_o,
  output logic      oe_o,
  output logic      rd_o
);
  assign oe_o    = dir_i;
  assign drive_o = out_val_i;
  assign rd_o    = dir_i ? out_val_i : pin_level_i;
endmodule
`default_nettype wire

// ==== core/pagp_pkg.sv ====
package pagp_pkg;

  typedef logic [7:0] pagp_byte_type;

  // operating mode pins decoded to the two pin-7 families
  typedef enum logic [2:0] {
    PAGP_MODE0 = 3'h0,
    PAGP_MODE1 = 3'h1,
    PAGP_MODE2 = 3'h2,
    PAGP_MODE3 = 3'h3,
    PAGP_MODE4 = 3'h4,
    PAGP_MODE5 = 3'h5,
    PAGP_MODE6 = 3'h6,
    PAGP_MODE7 = 3'h7
  } pagp_mode_type;

  // pin 7 function as selected by the priority chain
  typedef enum logic [2:0] {
    PAGP_FN_INPUT,
    PAGP_FN_PORT_OUT,
    PAGP_FN_PATTERN_OUT,
    PAGP_FN_TIMER_OUT,
    PAGP_FN_ADDR_OUT
  } pagp_fn_type;

endpackage

// ==== core/pagp_port_a.sv ====
// The strobed register port and the register addresses were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "pagp_cfg.svh"
module pagp_port_a (
  input  wire logic                  core_clk_i,
  input  wire logic                  rstn_i,
  input  wire logic                  hw_standby_i,
  input  wire logic                  sw_standby_i,
  input  wire pagp_pkg::pagp_mode_type mode_i,
  input  wire logic [`PAGP_ADDR_W-1:0] addr_i,
  input  wire logic [7:0]            wdata_i,
  input  wire logic                  wr_i,
  input  wire logic                  rd_i,
  output logic [7:0]                 rdata_o,
  input  wire logic [7:0]            pin_in_i,
  output logic [7:0]                 pin_out_o,
  output logic [7:0]                 pin_oe_o,
  input  wire logic [7:0]            pattern_i,
  input  wire logic                  timer2_b_out_i,
  input  wire logic                  addr_bit_i,
  output logic                       timer2_b_pin_o,
  output logic [2:0]                 pin7_fn_o
);
  import pagp_pkg::*;

  logic [7:0] port_direction;
  logic [7:0] port_output_data;
  logic [7:0] ctrl;
  logic [7:0] rdata;

  wire clear_all = !rstn_i || hw_standby_i;
  wire addr_mode = (mode_i == PAGP_MODE3) || (mode_i == PAGP_MODE4) ||
                   (mode_i == PAGP_MODE6);
  wire [7:0] dir_rst = addr_mode ? `PAGP_DIR_RST_ADDR : `PAGP_DIR_RST_LOW;
  wire wr_dir  = wr_i && (addr_i == `PAGP_OFF_DIR);
  wire wr_data = wr_i && (addr_i == `PAGP_OFF_DATA);
  wire wr_ctrl = wr_i && (addr_i == `PAGP_OFF_CTRL);

  // bit 7 forced in address modes, writes there ignored
  wire [7:0] next_dir = {wdata_i[7] | addr_mode, wdata_i[6:0]};

  wire pin7_pattern_enable = ctrl[`PAGP_CTRL_PAT7];
  wire timer2_b_ctrl_bit0  = ctrl[`PAGP_CTRL_TIMER2_B_CTRL_BIT0];
  wire timer2_b_ctrl_bit1  = ctrl[`PAGP_CTRL_TIMER2_B_CTRL_BIT1];
  wire timer2_b_ctrl_bit2  = ctrl[`PAGP_CTRL_TIMER2_B_CTRL_BIT2];
  wire timer2_pwm_select   = ctrl[`PAGP_CTRL_TIMER2_PWM_SELECT];

  // hardware standby clears like reset; software standby gates nothing and simply holds state
  always_ff @(posedge core_clk_i) begin
    if (clear_all) begin
      port_direction   <= dir_rst;
      port_output_data <= `PAGP_DATA_RST;
      ctrl             <= `PAGP_CTRL_RST;
    end else begin
      if (wr_dir)
        port_direction <= next_dir;
      else if (addr_mode)
        port_direction[`PAGP_PIN7] <= 1'b1;
      if (wr_data)
        port_output_data <= wdata_i;
      if (wr_ctrl)
        ctrl <= wdata_i;
    end
  end

  wire [7:0] cell_out;
  wire [7:0] cell_oe;
  wire [7:0] cell_rd;
  genvar g;
  generate
    for (g = 0; g < 8; g = g + 1) begin : g_pin
      pagp_pin_cell u_cell (
        .dir_i       (port_direction[g]),
        .out_val_i   (port_output_data[g]),
        .pin_level_i (pin_in_i[g]),
        .drive_o     (cell_out[g]),
        .oe_o        (cell_oe[g]),
        .rd_o        (cell_rd[g])
      );
    end
  endgenerate

  // compare output selected for 001 and 01x
  wire timer_sel = !timer2_b_ctrl_bit2 &&
                   (timer2_b_ctrl_bit1 || timer2_b_ctrl_bit0);

  pagp_fn_type fn7;
  always_comb begin
    if (addr_mode)
      fn7 = PAGP_FN_ADDR_OUT;
    else if (timer_sel)
      fn7 = PAGP_FN_TIMER_OUT;
    else if (!port_direction[`PAGP_PIN7])
      fn7 = PAGP_FN_INPUT;
    else if (!pin7_pattern_enable)
      fn7 = PAGP_FN_PORT_OUT;
    else
      fn7 = PAGP_FN_PATTERN_OUT;
  end

  logic p7_out;
  logic p7_oe;
  always_comb begin
    p7_out = cell_out[`PAGP_PIN7];
    p7_oe  = cell_oe[`PAGP_PIN7];
    unique case (fn7)
      PAGP_FN_ADDR_OUT: begin
        p7_out = addr_bit_i;
        p7_oe  = 1'b1;
      end
      PAGP_FN_TIMER_OUT: begin
        p7_out = timer2_b_out_i;
        p7_oe  = 1'b1;
      end
      PAGP_FN_INPUT: begin
        p7_out = cell_out[`PAGP_PIN7];
        p7_oe  = 1'b0;
      end
      PAGP_FN_PORT_OUT: begin
        p7_out = cell_out[`PAGP_PIN7];
        p7_oe  = 1'b1;
      end
      PAGP_FN_PATTERN_OUT: begin
        p7_out = pattern_i[`PAGP_PIN7];
        p7_oe  = 1'b1;
      end
    endcase
  end

  // pins 6..0 stay plain port pins here
  assign pin_out_o = {p7_out, cell_out[6:0]};
  assign pin_oe_o  = {p7_oe, cell_oe[6:0]};
  assign pin7_fn_o = fn7;

  // capture path only while pin 7 is a port or pattern pin
  wire p7_port_fn = (fn7 == PAGP_FN_INPUT) || (fn7 == PAGP_FN_PORT_OUT) ||
                    (fn7 == PAGP_FN_PATTERN_OUT);
  wire p7_level   = p7_oe ? p7_out : pin_in_i[`PAGP_PIN7];
  assign timer2_b_pin_o = p7_port_fn && timer2_b_ctrl_bit2 &&
                          !timer2_pwm_select && p7_level;

  wire [7:0] read_mux =
    (addr_i == `PAGP_OFF_DIR)    ? `PAGP_DIR_READ :
    (addr_i == `PAGP_OFF_DATA)   ? cell_rd :
    (addr_i == `PAGP_OFF_CTRL)   ? ctrl :
    (addr_i == `PAGP_OFF_STATUS) ? {5'h00, fn7} : 8'h00;

  always_ff @(posedge core_clk_i) begin
    if (!rstn_i)
      rdata <= 8'h00;
    else
      rdata <= rd_i ? read_mux : 8'h00;
  end
  assign rdata_o = rdata;

  property p_dir_read_ones;
    @(posedge core_clk_i) disable iff (!rstn_i)
      rd_i && addr_i == `PAGP_OFF_DIR |=> rdata_o == 8'hff;
  endproperty
  a_dir_read_ones: assert property (p_dir_read_ones)
    else $error("direction read not all ones");

  property p_oe_follows_dir;
    @(posedge core_clk_i) disable iff (!rstn_i)
      pin_oe_o[6:0] == port_direction[6:0];
  endproperty
  a_oe_follows_dir: assert property (p_oe_follows_dir)
    else $error("pin enable differs from direction");

  property p_addr_mode_pin7;
    @(posedge core_clk_i) disable iff (!rstn_i)
      addr_mode && !hw_standby_i |=> port_direction[7] && pin_oe_o[7];
  endproperty
  a_addr_mode_pin7: assert property (p_addr_mode_pin7)
    else $error("pin 7 not address output");

  property p_reset_dir;
    @(posedge core_clk_i)
      hw_standby_i |=> port_direction == $past(dir_rst)
                       && port_output_data == 8'h00;
  endproperty
  a_reset_dir: assert property (p_reset_dir)
    else $error("direction or data reset value wrong");

  property p_swstby_hold;
    @(posedge core_clk_i) disable iff (!rstn_i || hw_standby_i)
      sw_standby_i && !wr_i ##1 !hw_standby_i |->
        $stable(port_direction) && $stable(port_output_data);
  endproperty
  a_swstby_hold: assert property (p_swstby_hold)
    else $error("state lost in software standby");

  property p_data_read;
    @(posedge core_clk_i) disable iff (!rstn_i)
      rd_i && addr_i == `PAGP_OFF_DATA |=>
        rdata_o == $past(cell_rd);
  endproperty
  a_data_read: assert property (p_data_read)
    else $error("data read mismatch");

  property p_data_write;
    @(posedge core_clk_i) disable iff (!rstn_i || hw_standby_i)
      wr_data ##1 !hw_standby_i && rstn_i |-> port_output_data == $past(wdata_i);
  endproperty
  a_data_write: assert property (p_data_write)
    else $error("data write not taken at edge");

  property p_timer_out;
    @(posedge core_clk_i) disable iff (!rstn_i)
      !addr_mode && timer_sel |-> pin_oe_o[7] && pin_out_o[7] == timer2_b_out_i;
  endproperty
  a_timer_out: assert property (p_timer_out)
    else $error("pin 7 not timer output");

  property p_release;
    @(posedge core_clk_i) disable iff (!rstn_i)
      !addr_mode && ctrl[`PAGP_CTRL_TIMER2_B_CTRL_BIT2] |-> fn7 != PAGP_FN_TIMER_OUT;
  endproperty
  a_release: assert property (p_release)
    else $error("pin 7 not released");

  property p_capture;
    @(posedge core_clk_i) disable iff (!rstn_i)
      timer2_b_pin_o |-> ctrl[`PAGP_CTRL_TIMER2_B_CTRL_BIT2] && !ctrl[`PAGP_CTRL_TIMER2_PWM_SELECT]
                         && !addr_mode;
  endproperty
  a_capture: assert property (p_capture)
    else $error("capture routed wrongly");

  property p_oe7_follows_dir;
    @(posedge core_clk_i) disable iff (!rstn_i)
      !addr_mode && !timer_sel |-> pin_oe_o[7] == port_direction[7];
  endproperty
  a_oe7_follows_dir: assert property (p_oe7_follows_dir)
    else $error("pin 7 enable differs from direction");

  property p_low_pins_drive;
    @(posedge core_clk_i) disable iff (!rstn_i)
      pin_out_o[6:0] == port_output_data[6:0];
  endproperty
  a_low_pins_drive: assert property (p_low_pins_drive)
    else $error("pin drive differs from data");

  property p_pattern_drive;
    @(posedge core_clk_i) disable iff (!rstn_i)
      fn7 == PAGP_FN_PATTERN_OUT |->
        pin_oe_o[7] && pin_out_o[7] == pattern_i[7];
  endproperty
  a_pattern_drive: assert property (p_pattern_drive)
    else $error("pin 7 not pattern output");

  property p_port_drive7;
    @(posedge core_clk_i) disable iff (!rstn_i)
      fn7 == PAGP_FN_PORT_OUT |->
        pin_oe_o[7] && pin_out_o[7] == port_output_data[7];
  endproperty
  a_port_drive7: assert property (p_port_drive7)
    else $error("pin 7 not port output");

  property p_addr_drive;
    @(posedge core_clk_i) disable iff (!rstn_i)
      addr_mode |-> pin_oe_o[7] && pin_out_o[7] == addr_bit_i;
  endproperty
  a_addr_drive: assert property (p_addr_drive)
    else $error("pin 7 not driving the address bit");

  property p_dir_write;
    @(posedge core_clk_i) disable iff (!rstn_i || hw_standby_i)
      wr_dir && !addr_mode |=> port_direction == $past(wdata_i);
  endproperty
  a_dir_write: assert property (p_dir_write)
    else $error("direction write not taken at edge");

  property p_dir_write_addr;
    @(posedge core_clk_i) disable iff (!rstn_i || hw_standby_i)
      wr_dir && addr_mode |=>
        port_direction == {1'b1, $past(wdata_i[6:0])};
  endproperty
  a_dir_write_addr: assert property (p_dir_write_addr)
    else $error("direction bit 7 not held in address mode");

  property p_rdata_idle;
    @(posedge core_clk_i) disable iff (!rstn_i)
      !rd_i |=> rdata_o == 8'h00;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle)
    else $error("read data outside its cycle");

  property p_status_read;
    @(posedge core_clk_i) disable iff (!rstn_i)
      rd_i && addr_i == `PAGP_OFF_STATUS |=>
        rdata_o == {5'h00, $past(fn7)};
  endproperty
  a_status_read: assert property (p_status_read)
    else $error("status read mismatch");

  property p_reset_dir_rstn;
    @(posedge core_clk_i)
      !rstn_i |=> port_direction == $past(dir_rst);
  endproperty
  a_reset_dir_rstn: assert property (p_reset_dir_rstn)
    else $error("direction reset value wrong");

  property p_reset_data;
    @(posedge core_clk_i)
      !rstn_i |=> port_output_data == 8'h00;
  endproperty
  a_reset_data: assert property (p_reset_data)
    else $error("data not cleared by reset");

  property p_swstby_oe;
    @(posedge core_clk_i) disable iff (!rstn_i || hw_standby_i)
      sw_standby_i && !wr_i |=> $stable(pin_oe_o);
  endproperty
  a_swstby_oe: assert property (p_swstby_oe)
    else $error("pin enables changed in software standby");

  property p_capture_level;
    @(posedge core_clk_i) disable iff (!rstn_i)
      p7_port_fn && timer2_b_ctrl_bit2 && !timer2_pwm_select |->
        timer2_b_pin_o == pin_in_i[`PAGP_PIN7];
  endproperty
  a_capture_level: assert property (p_capture_level)
    else $error("capture input not the pin level");

  property p_timer_select;
    @(posedge core_clk_i) disable iff (!rstn_i)
      !addr_mode &&
        ctrl[`PAGP_CTRL_TIMER2_B_CTRL_BIT2:`PAGP_CTRL_TIMER2_B_CTRL_BIT0] inside {3'h1, 3'h2, 3'h3}
        |-> fn7 == PAGP_FN_TIMER_OUT;
  endproperty
  a_timer_select: assert property (p_timer_select)
    else $error("compare output not selected");

  property p_timer_off;
    @(posedge core_clk_i) disable iff (!rstn_i)
      !addr_mode && ctrl[`PAGP_CTRL_TIMER2_B_CTRL_BIT2:`PAGP_CTRL_TIMER2_B_CTRL_BIT0] == 3'h0
        |-> fn7 != PAGP_FN_TIMER_OUT;
  endproperty
  a_timer_off: assert property (p_timer_off)
    else $error("pin 7 not released at zero control");

endmodule
`default_nettype wire

// ==== verif/pagp_pin_env.sv ====
`timescale 1ns/1ps
`default_nettype none
// far side: a driven pin reads back its own drive, others the outside
module pagp_pin_env (
  input  wire logic [7:0] out_i,
  input  wire logic [7:0] oe_i,
  input  wire logic [7:0] ext_i,
  output logic      [7:0] lvl_o
);
  assign lvl_o = (out_i & oe_i) | (ext_i & ~oe_i);
endmodule
`default_nettype wire

// ==== verif/testbench.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "pagp_cfg.svh"
module testbench;
  import pagp_pkg::*;
  logic            clk = 1'b0;
  logic            rstn = 1'b0;
  logic            hw_sb = 1'b0;
  logic            sw_sb = 1'b0;
  pagp_mode_type   mode = PAGP_MODE1;
  logic [3:0]      addr = 4'h0;
  logic [7:0]      wdata = 8'h00;
  logic            wr = 1'b0;
  logic            rd = 1'b0;
  logic [7:0]      pat = 8'h80;
  logic            tmr = 1'b1;
  logic            abit = 1'b1;
  logic [7:0]      ext = 8'h00;
  wire logic [7:0] rdata;
  wire logic [7:0] pout;
  wire logic [7:0] poe;
  wire logic [7:0] plvl;
  wire logic       cap;
  wire logic [2:0] fn;
  int              errors = 0;
  int              compares = 0;
  logic [7:0]      r;
  logic [2:0]      iob;
  logic [2:0]      efn;
  logic            tsel;
  // dir, data, outside level, expected data read
  logic [7:0] rows [4][4] = '{'{8'h0f, 8'ha5, 8'h3c, 8'h35},
    '{8'hff, 8'h5a, 8'h00, 8'h5a}, '{8'h00, 8'hff, 8'hc3, 8'hc3},
    '{8'h81, 8'h7e, 8'h5a, 8'h5a}};

  always #2.5 clk = ~clk;

  pagp_port_a dut_u (.core_clk_i(clk), .rstn_i(rstn), .hw_standby_i(hw_sb),
    .sw_standby_i(sw_sb), .mode_i(mode), .addr_i(addr), .wdata_i(wdata),
    .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .pin_in_i(plvl),
    .pin_out_o(pout), .pin_oe_o(poe), .pattern_i(pat),
    .timer2_b_out_i(tmr), .addr_bit_i(abit), .timer2_b_pin_o(cap),
    .pin7_fn_o(fn));
  pagp_pin_env env_u (.out_i(pout), .oe_i(poe), .ext_i(ext), .lvl_o(plvl));

  task chk(input logic [7:0] g, input logic [7:0] e);
    compares++;
    if (g !== e) begin
      errors++;
      $display("mismatch t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task wreg(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    #1;
  endtask
  task rreg(input logic [3:0] a);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    r = rdata;
  endtask
  task reset_to(input pagp_mode_type m);
    mode <= m;
    rstn <= 1'b0;
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    #1;
  endtask
  task done(input string s);
    $display("test %s done", s);
  endtask
  task complete_run;
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  initial begin
    reset_to(PAGP_MODE1);
    chk(poe, 8'h00);
    chk({5'h0, fn}, 8'h00);
    ext <= 8'h96;
    rreg(`PAGP_OFF_DATA);
    chk(r, 8'h96);
    chk(pout, 8'h00);
    @(posedge clk);
    #1;
    chk(rdata, 8'h00);
    done("reset");
    for (int i = 0; i < 4; i++) begin
      ext <= rows[i][2];
      wreg(`PAGP_OFF_DIR, rows[i][0]);
      chk(poe, rows[i][0]);
      wreg(`PAGP_OFF_DATA, rows[i][1]);
      chk(pout & poe, rows[i][1] & rows[i][0]);
      rreg(`PAGP_OFF_DIR);
      chk(r, 8'hff);
      rreg(`PAGP_OFF_DATA);
      chk(r, rows[i][3]);
    end
    done("table");
    sw_sb <= 1'b1;
    repeat (3) @(posedge clk);
    #1;
    chk(poe, 8'h81);
    chk(pout, 8'h7e);
    sw_sb <= 1'b0;
    ext <= 8'h00;
    rreg(`PAGP_OFF_DATA);
    chk(r, 8'h00);
    hw_sb <= 1'b1;
    repeat (2) @(posedge clk);
    hw_sb <= 1'b0;
    #1;
    chk(poe, 8'h00);
    wreg(`PAGP_OFF_DIR, 8'hff);
    rreg(`PAGP_OFF_DATA);
    chk(r, 8'h00);
    rreg(4'h5);
    chk(r, 8'h00);
    done("standby");
    // pattern use needs the pin driving first
    wreg(`PAGP_OFF_DIR, 8'h80);
    wreg(`PAGP_OFF_DATA, 8'h00);
    for (int c = 0; c < 32; c++) begin
      // timer level varies so timer, port and pattern drives differ
      tmr <= c[4];
      wreg(`PAGP_OFF_CTRL, c[7:0]);
      iob = c[3:1];
      tsel = (iob == 3'h1) || (iob[2:1] == 2'h1);
      efn = tsel ? 3'h3 : (c[0] ? 3'h2 : 3'h1);
      chk({5'h0, fn}, {5'h0, efn});
      chk({7'h0, pout[7]}, {7'h0, tsel ? c[4] : c[0]});
      chk({7'h0, cap}, {7'h0, iob[2] & ~c[4] & c[0]});
    end
    wreg(`PAGP_OFF_CTRL, 8'h00);
    wreg(`PAGP_OFF_DIR, 8'h00);
    chk({5'h0, fn}, 8'h00);
    done("pin7");
    reset_to(PAGP_MODE3);
    chk(poe, 8'h80);
    chk({5'h0, fn}, 8'h04);
    abit <= 1'b0;
    wreg(`PAGP_OFF_DIR, 8'h00);
    chk(poe, 8'h80);
    chk({7'h0, pout[7]}, 8'h00);
    wreg(`PAGP_OFF_DIR, 8'h01);
    chk(poe, 8'h81);
    rreg(`PAGP_OFF_STATUS);
    chk(r, 8'h04);
    done("mode3");
    complete_run();
  end
endmodule
`default_nettype wire
